/* File: logic/stfm_fault_mgr.sv */
// supply and thermal fault supervision for five high-side channels
// What this block does
// - persistent overtemperature switches that channel off
// - overtemperature sets channel status only
// - normal mode restart needs cool and write
// - overtemperature status holds until cool and read
// - fail mode overtemperature restart needs mode transition
// - persistent undervoltage switches all outputs off
// - undervoltage sets summary and battery low
// - normal mode undervoltage restart needs write
// - battery low holds until cleared and read
// - fail mode undervoltage restarts automatically
// - auto restart interval about sixty-four ms
// - overvoltage sets flags, outputs keep running
// - battery high holds until cleared and read
// - outputs off until pump settles, commands held
// - pump out of range switches outputs off
// - pump failure sets summary and quick flag
// - held command runs with fresh inrush windows
// - pump flag holds until valid and read
`timescale 1ns/1ps
`default_nettype none
`include "stfm_consts.svh"

module stfm_fault_mgr #(
   parameter int AUTO_RESTART_CYC = `STFM_AUTO_RESTART_CYC
) (
   input  wire logic       CLK,
   input  wire logic       RST,
   input  wire logic [4:0] OT_RAW,
   input  wire logic       UV_RAW,
   input  wire logic       OV_RAW,
   input  wire logic       CP_BAD_RAW,
   input  wire logic       FAIL_MODE,
   input  wire logic       MODE_TRANS,
   input  wire logic       ON_WR,
   input  wire logic [4:0] ON_DATA,
   input  wire logic       RD_QUICK,
   input  wire logic [4:0] RD_CHAN,
   input  wire logic       RD_DEV,
   output logic      [4:0] OUT_EN,
   output logic      [4:0] OVERTEMP_SHUTDOWN,
   output logic            BATTERY_LOW_FLAG,
   output logic            BATTERY_HIGH_FLAG,
   output logic            PUMP_FAIL_FLAG,
   output logic            DEVICE_FAULT_SUMMARY,
   output logic      [4:0] INRUSH_CURRENT_WINDOW_RESTART
);
   localparam logic [`STFM_AR_W-1:0] AR_LAST =
      `STFM_AR_W'(AUTO_RESTART_CYC - 1);

   // sticky flag update, set wins over clear
   function automatic logic flag_upd(input logic flag,
                                     input logic set,
                                     input logic clr);
      flag_upd = set | (flag & ~clr);
   endfunction : flag_upd

   logic [7:0]              raw_m_r;
   logic [7:0]              raw_s_r;
   logic [4:0]              ot_s;
   logic                    uv_s;
   logic                    ov_s;
   logic                    cp_s;
   logic [4:0]              ot_q;
   logic                    uv_q;
   logic                    ov_q;
   logic                    cp_q;
   logic [4:0]              cmd_on_r;
   logic [4:0]              ots_lock_r;
   logic [4:0]              uv_lock_r;
   logic                    cp_off_r;
   logic                    pump_settled_r;
   logic                    pump_ok;
   logic [4:0]              out_en_nxt;
   logic [4:0]              out_en_r;
   logic [4:0]              inrush_r;
   logic [4:0]              ots_flag_r;
   logic                    low_r;
   logic                    high_r;
   logic                    pump_r;
   logic                    summary_r;
   stfm_pkg::stfm_ar_t      ar_st_r;
   logic [`STFM_AR_W-1:0]   ar_cnt_r;
   logic                    ar_fire;

   // two-stage synchroniser for the analog comparator levels
   // pump level starts bad, so power-up waits for a real good level
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         raw_m_r <= 8'h80;
         raw_s_r <= 8'h80;
      end
      else
      begin
         raw_m_r <= {CP_BAD_RAW, OV_RAW, UV_RAW, OT_RAW};
         raw_s_r <= raw_m_r;
      end
   end

   assign ot_s = raw_s_r[4:0];
   assign uv_s = raw_s_r[`STFM_SLOT_UV];
   assign ov_s = raw_s_r[`STFM_SLOT_OV];
   assign cp_s = raw_s_r[`STFM_SLOT_CP];

   // one deglitch filter per fault condition
   stfm_flt_if flt_if [`STFM_SLOTS] ();

   genvar g;
   generate
      for (g = 0; g < `STFM_SLOTS; g++)
      begin : g_filt
         localparam int FCYC =
            (g < `STFM_CHANNELS)   ? `STFM_OT_FILTER_CYC :
            (g == `STFM_SLOT_UV)   ? `STFM_UV_FILTER_CYC :
            (g == `STFM_SLOT_OV)   ? `STFM_OV_FILTER_CYC :
                                     `STFM_CP_FILTER_CYC;
         assign flt_if[g].raw = raw_s_r[g];
         stfm_deglitch #(
            .CYC (`STFM_FILT_W'(FCYC))
         ) u_filt (
            .clk (CLK),
            .rst (RST),
            .f   (flt_if[g])
         );
         if (g < `STFM_CHANNELS)
         begin : g_ot
            assign ot_q[g] = flt_if[g].hit;
         end
      end
   endgenerate

   assign uv_q = flt_if[`STFM_SLOT_UV].hit;
   assign ov_q = flt_if[`STFM_SLOT_OV].hit;
   assign cp_q = flt_if[`STFM_SLOT_CP].hit;

   // commanded on state, kept while outputs are blocked
   always_ff @(posedge CLK)
   begin
      if (RST)
         cmd_on_r <= 5'h00;
      else if (ON_WR)
         cmd_on_r <= ON_DATA;
   end

   // per channel overtemperature lockout
   always_ff @(posedge CLK)
   begin
      if (RST)
         ots_lock_r <= 5'h00;
      else
         for (int i = 0; i < `STFM_CHANNELS; i++)
            ots_lock_r[i] <= flag_upd(ots_lock_r[i], ot_q[i],
               ~ot_s[i] & (FAIL_MODE ? MODE_TRANS
                                     : ON_WR & ON_DATA[i]));
   end

   // undervoltage lockout, write restart or auto restart
   always_ff @(posedge CLK)
   begin
      if (RST)
         uv_lock_r <= 5'h00;
      else
         for (int i = 0; i < `STFM_CHANNELS; i++)
            uv_lock_r[i] <= flag_upd(uv_lock_r[i], uv_q,
               FAIL_MODE ? ar_fire
                         : ON_WR & ON_DATA[i] & ~uv_s);
   end

   // pump state: settled once after reset, off while failed
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         pump_settled_r <= 1'b0;
         cp_off_r       <= 1'b0;
      end
      else
      begin
         if (!cp_s)
            pump_settled_r <= 1'b1;
         cp_off_r <= flag_upd(cp_off_r, cp_q, ~cp_s);
      end
   end

   assign pump_ok = pump_settled_r & ~cp_off_r & ~cp_q;

   // fault gated output enables, cut in the cycle after qualification
   assign out_en_nxt = cmd_on_r & ~ots_lock_r & ~ot_q
                     & ~uv_lock_r & {5{~uv_q}}
                     & {5{pump_ok}};

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         out_en_r <= 5'h00;
         inrush_r <= 5'h00;
      end
      else
      begin
         out_en_r <= out_en_nxt;
         inrush_r <= out_en_nxt & ~out_en_r;
      end
   end

   // per channel overtemperature status
   always_ff @(posedge CLK)
   begin
      if (RST)
         ots_flag_r <= 5'h00;
      else
         for (int i = 0; i < `STFM_CHANNELS; i++)
            ots_flag_r[i] <= flag_upd(ots_flag_r[i], ot_q[i],
                                      RD_CHAN[i] & ~ot_s[i]);
   end

   // device level sticky flags
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         low_r     <= 1'b0;
         high_r    <= 1'b0;
         pump_r    <= 1'b0;
         summary_r <= 1'b0;
      end
      else
      begin
         low_r     <= flag_upd(low_r, uv_q, RD_DEV & ~uv_s);
         high_r    <= flag_upd(high_r, ov_q, RD_DEV & ~ov_s);
         pump_r    <= flag_upd(pump_r, cp_q, RD_QUICK & ~cp_s);
         summary_r <= low_r | high_r | pump_r;
      end
   end

   // fail mode auto restart sequencer
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         ar_st_r  <= stfm_pkg::STFM_AR_IDLE;
         ar_cnt_r <= '0;
      end
      else
      begin
         unique case (ar_st_r)
            stfm_pkg::STFM_AR_IDLE:
            begin
               ar_cnt_r <= '0;
               if (FAIL_MODE && (|uv_lock_r))
                  ar_st_r <= stfm_pkg::STFM_AR_WAIT;
            end
            stfm_pkg::STFM_AR_WAIT:
            begin
               if (!FAIL_MODE)
                  ar_st_r <= stfm_pkg::STFM_AR_IDLE;
               else if (ar_cnt_r == AR_LAST)
               begin
                  ar_cnt_r <= '0;
                  if (!uv_s && !uv_q)
                     ar_st_r <= stfm_pkg::STFM_AR_FIRE;
               end
               else
                  ar_cnt_r <= ar_cnt_r + 23'h000001;
            end
            stfm_pkg::STFM_AR_FIRE:
               ar_st_r <= stfm_pkg::STFM_AR_IDLE;
            default:
               ar_st_r <= stfm_pkg::STFM_AR_IDLE;
         endcase
      end
   end

   assign ar_fire = (ar_st_r == stfm_pkg::STFM_AR_FIRE);

   // outputs straight from flip-flops
   assign OUT_EN                        = out_en_r;
   assign OVERTEMP_SHUTDOWN             = ots_flag_r;
   assign BATTERY_LOW_FLAG              = low_r;
   assign BATTERY_HIGH_FLAG             = high_r;
   assign PUMP_FAIL_FLAG                = pump_r;
   assign DEVICE_FAULT_SUMMARY          = summary_r;
   assign INRUSH_CURRENT_WINDOW_RESTART = inrush_r;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   a_ots_output_off: assert property (
      1'b1 |=> (($past(ot_q) & out_en_r) == 5'h00))
      else $error("channel still on after overtemperature");
   a_ots_flag_set: assert property (
      (|ot_q) |=> ((ots_flag_r & $past(ot_q)) == $past(ot_q)))
      else $error("overtemperature status not set");
   a_ots_normal_lock: assert property (
      (!FAIL_MODE && !ON_WR) |=>
         ((ots_lock_r & $past(ots_lock_r)) == $past(ots_lock_r)))
      else $error("overtemperature lock released without a write");
   a_ots_flag_hold: assert property (
      (|(ots_flag_r & ot_s)) |=>
         ((ots_flag_r & $past(ots_flag_r & ot_s)) ==
          $past(ots_flag_r & ot_s)))
      else $error("overtemperature status lost while still hot");
   a_ots_fail_lock: assert property (
      (FAIL_MODE && !MODE_TRANS) |=>
         ((ots_lock_r & $past(ots_lock_r)) == $past(ots_lock_r)))
      else $error("fail mode lock released without mode transition");
   a_uv_all_off: assert property (
      uv_q |=> (out_en_r == 5'h00))
      else $error("outputs on during undervoltage");
   a_uv_flag_chain: assert property (
      uv_q |=> low_r ##1 summary_r)
      else $error("undervoltage not reported");
   a_uv_normal_lock: assert property (
      (!FAIL_MODE && !ON_WR && !uv_q) |=> (uv_lock_r == $past(uv_lock_r)))
      else $error("undervoltage lock changed without a write");
   a_uv_flag_hold: assert property (
      (low_r && uv_s) |=> low_r)
      else $error("battery low flag lost while condition present");
   a_ar_interval: assert property (
      (ar_st_r == stfm_pkg::STFM_AR_FIRE) |->
         ($past(ar_cnt_r) == AR_LAST))
      else $error("auto restart fired at the wrong count");
   a_ar_clears_lock: assert property (
      (ar_fire && FAIL_MODE && !uv_q) |=> (uv_lock_r == 5'h00))
      else $error("auto restart did not release outputs");
   a_ov_flag_hold: assert property (
      (ov_q || (high_r && ov_s)) |=> high_r)
      else $error("battery high flag not set or not held");
   a_ov_no_cut: assert property (
      (ov_q && !uv_q && !cp_q && pump_ok && ots_lock_r == 5'h00 &&
       ot_q == 5'h00 && uv_lock_r == 5'h00) |=>
         (out_en_r == $past(cmd_on_r)))
      else $error("overvoltage switched an output off");
   a_pump_settle: assert property (
      !pump_settled_r |=> (out_en_r == 5'h00))
      else $error("output on before pump settled");
   a_cp_all_off: assert property (
      cp_q |=> ((out_en_r == 5'h00) && pump_r))
      else $error("outputs on or flag missing during pump failure");
   a_inrush_restart: assert property (
      1'b1 |=> (inrush_r == (out_en_r & ~$past(out_en_r))))
      else $error("inrush window restart does not match turn on");
   a_cp_flag_hold: assert property (
      (pump_r && cp_s) |=> pump_r)
      else $error("pump fail flag cleared while pump invalid");
endmodule : stfm_fault_mgr

`default_nettype wire

/* File: include/stfm_consts.svh */
// timing and width constants of the supply and thermal fault manager
`ifndef STFM_CONSTS_SVH
`define STFM_CONSTS_SVH

`define STFM_CHANNELS          5
`define STFM_CLK_MHZ           125
// filter times in ns
`define STFM_OT_FILTER_NS      5000
`define STFM_UV_FILTER_NS      3500
`define STFM_OV_FILTER_NS      3500
`define STFM_CP_FILTER_NS      4000
// least times round up to whole cycles
`define STFM_NS_TO_CYC(ns)     (((ns) * `STFM_CLK_MHZ + 999) / 1000)
`define STFM_OT_FILTER_CYC     `STFM_NS_TO_CYC(`STFM_OT_FILTER_NS)
`define STFM_UV_FILTER_CYC     `STFM_NS_TO_CYC(`STFM_UV_FILTER_NS)
`define STFM_OV_FILTER_CYC     `STFM_NS_TO_CYC(`STFM_OV_FILTER_NS)
`define STFM_CP_FILTER_CYC     `STFM_NS_TO_CYC(`STFM_CP_FILTER_NS)
// fail mode auto restart interval in ms
`define STFM_AUTO_RESTART_MS   64
`define STFM_AUTO_RESTART_CYC  (`STFM_AUTO_RESTART_MS * `STFM_CLK_MHZ * 1000)
`define STFM_FILT_W            10
`define STFM_AR_W              23
// filter slot numbers beyond the five channels
`define STFM_SLOT_UV           5
`define STFM_SLOT_OV           6
`define STFM_SLOT_CP           7
`define STFM_SLOTS             8

`endif

/* File: include/stfm_pkg.sv */
// types of the supply and thermal fault manager
package stfm_pkg;

   // auto restart sequencer, gray coded along idle-wait-fire
   typedef enum logic [1:0] {
      STFM_AR_IDLE = 2'h0,
      STFM_AR_WAIT = 2'h1,
      STFM_AR_FIRE = 2'h3
   } stfm_ar_t;

endpackage : stfm_pkg

/* File: include/stfm_flt_if.sv */
// link between the fault manager and one deglitch filter
`timescale 1ns/1ps
`default_nettype none

interface stfm_flt_if;
   logic raw;   // synchronised raw condition
   logic hit;   // condition held for the full filter time

   modport filt (input raw, output hit);
   modport user (output raw, input hit);
endinterface : stfm_flt_if

`default_nettype wire

/* File: logic/stfm_deglitch.sv */
// deglitch filter for one fault condition
`timescale 1ns/1ps
`default_nettype none
`include "stfm_consts.svh"

module stfm_deglitch #(
   parameter logic [`STFM_FILT_W-1:0] CYC = 10'h001
) (
   input  wire logic clk,
   input  wire logic rst,
   stfm_flt_if.filt  f
);
   logic [`STFM_FILT_W-1:0] cnt_r;

   // run while raw holds, back to zero on any drop
   always_ff @(posedge clk)
   begin
      if (rst || !f.raw)
         cnt_r <= '0;
      else if (cnt_r != CYC)
         cnt_r <= cnt_r + 10'h001;
   end

   // qualified level while raw stays after the full count
   assign f.hit = f.raw && (cnt_r == CYC);

   a_filter_restart: assert property (@(posedge clk) disable iff (rst)
      !f.raw |=> (cnt_r == '0))
      else $error("filter count not cleared after raw dropped");
   a_filter_qualify: assert property (@(posedge clk) disable iff (rst)
      (f.raw && cnt_r == CYC - 10'h001) |=> (f.hit == f.raw))
      else $error("filter did not qualify on the last count");
endmodule : stfm_deglitch

`default_nettype wire

/* File: tb/stfm_mcu_model.sv */
// behavioural controller issuing on writes and status reads
`timescale 1ns/1ps
`default_nettype none

module stfm_mcu_model (
   input  wire logic       clk,
   output logic            on_wr,
   output logic      [4:0] on_data,
   output logic            rd_quick,
   output logic      [4:0] rd_chan,
   output logic            rd_dev
);
   // strobes idle from time zero
   initial
   begin
      on_wr    = 1'b0;
      on_data  = 5'h00;
      rd_quick = 1'b0;
      rd_chan  = 5'h00;
      rd_dev   = 1'b0;
   end

   // one-cycle on-bit write; data scrambled once released
   task automatic wr_on(input logic [4:0] d);
      @(posedge clk);
      on_wr   <= 1'b1;
      on_data <= d;
      @(posedge clk);
      on_wr   <= 1'b0;
      on_data <= ~d;
   endtask : wr_on

   // one-cycle status read of quick, channel or device register
   task automatic rd(input logic q, input logic [4:0] c, input logic d);
      @(posedge clk);
      rd_quick <= q;
      rd_chan  <= c;
      rd_dev   <= d;
      @(posedge clk);
      rd_quick <= 1'b0;
      rd_chan  <= 5'h00;
      rd_dev   <= 1'b0;
   endtask : rd
endmodule : stfm_mcu_model

`default_nettype wire

/* File: tb/stfm_fault_mgr_tb_top.sv */
// self-checking bench of the supply and thermal fault manager
`timescale 1ns/1ps
`default_nettype none
`include "stfm_consts.svh"

module stfm_fault_mgr_tb_top;
   localparam int OT_N = `STFM_OT_FILTER_CYC;
   localparam int UV_N = `STFM_UV_FILTER_CYC;
   localparam int CP_N = `STFM_CP_FILTER_CYC;
   localparam int AR_N = 20;

   logic       clk;
   logic       rst;
   logic [4:0] ot_raw;
   logic       uv_raw;
   logic       ov_raw;
   logic       cp_bad;
   logic       fail_mode;
   logic       mode_trans;
   wire  logic       on_wr;
   wire  logic [4:0] on_data;
   wire  logic       rd_quick;
   wire  logic [4:0] rd_chan;
   wire  logic       rd_dev;
   wire  logic [4:0] out_en;
   wire  logic [4:0] overtemp_shutdown;
   wire  logic       bat_low;
   wire  logic       bat_high;
   wire  logic       pump_fail;
   wire  logic       summary;
   wire  logic [4:0] inrush;
   int         n_errors;
   int         samples_checked;
   int         inrush_cnt;
   int         cnt0;
   int         ch;
   logic [4:0] d;

   stfm_fault_mgr #(.AUTO_RESTART_CYC(AR_N)) DUT (
      .CLK                           (clk),
      .RST                           (rst),
      .OT_RAW                        (ot_raw),
      .UV_RAW                        (uv_raw),
      .OV_RAW                        (ov_raw),
      .CP_BAD_RAW                    (cp_bad),
      .FAIL_MODE                     (fail_mode),
      .MODE_TRANS                    (mode_trans),
      .ON_WR                         (on_wr),
      .ON_DATA                       (on_data),
      .RD_QUICK                      (rd_quick),
      .RD_CHAN                       (rd_chan),
      .RD_DEV                        (rd_dev),
      .OUT_EN                        (out_en),
      .OVERTEMP_SHUTDOWN             (overtemp_shutdown),
      .BATTERY_LOW_FLAG              (bat_low),
      .BATTERY_HIGH_FLAG             (bat_high),
      .PUMP_FAIL_FLAG                (pump_fail),
      .DEVICE_FAULT_SUMMARY          (summary),
      .INRUSH_CURRENT_WINDOW_RESTART (inrush)
   );

   stfm_mcu_model mcu (
      .clk      (clk),
      .on_wr    (on_wr),
      .on_data  (on_data),
      .rd_quick (rd_quick),
      .rd_chan  (rd_chan),
      .rd_dev   (rd_dev)
   );

   // free-running clock, 8 ns period
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // tally of inrush window restart pulses
   always @(posedge clk)
   begin
      if (rst)
         inrush_cnt <= 0;
      else
         inrush_cnt <= inrush_cnt + $countones(inrush);
   end

   // compare and count
   task automatic chk(input string what, input logic [4:0] seen,
                      input logic [4:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // enables expected after an on write with some channels locked
   function automatic logic [4:0] exp_en(input logic [4:0] dat,
                                         input logic [4:0] lock);
      return dat & ~lock;
   endfunction : exp_en

   // wait n edges, then let the updates settle
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc

   // verdict and end of run
   task automatic end_sim;
      if (n_errors == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : end_sim

   // watchdog against a hang
   initial
   begin
      repeat (20000) @(posedge clk);
      n_errors++;
      end_sim();
   end

   // main sequence
   initial
   begin
      void'($urandom(45591));
      n_errors = 0;
      samples_checked = 0;
      rst = 1'b1;
      ot_raw = 5'h00;
      uv_raw = 1'b0;
      ov_raw = 1'b0;
      cp_bad = 1'b1;
      fail_mode = 1'b0;
      mode_trans = 1'b0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      // on command held until the pump settles
      mcu.wr_on(5'h1f);
      cyc(20);
      chk("out_en", out_en, 5'h00);
      @(posedge clk) cp_bad <= 1'b0;
      cyc(10);
      chk("out_en", out_en, 5'h1f);
      chk("inrush", 5'(inrush_cnt), 5'h05);
      // overtemp with a glitch, then read and restart
      ch = $urandom_range(4, 0);
      @(posedge clk) ot_raw[ch] <= 1'b1;
      cyc(OT_N - 20);
      @(posedge clk) ot_raw[ch] <= 1'b0;
      cyc(3);
      @(posedge clk) ot_raw[ch] <= 1'b1;
      cyc(OT_N - 5);
      chk("out_en", out_en, 5'h1f);
      cyc(10);
      chk("out_en", out_en, exp_en(5'h1f, 5'h01 << ch));
      chk("ots", overtemp_shutdown, 5'h01 << ch);
      mcu.rd(1'b0, 5'h01 << ch, 1'b0);
      mcu.wr_on(5'h1f);
      cyc(4);
      chk("ots", overtemp_shutdown, 5'h01 << ch);
      chk("out_en", out_en, exp_en(5'h1f, 5'h01 << ch));
      @(posedge clk) ot_raw[ch] <= 1'b0;
      cyc(4);
      chk("ots", overtemp_shutdown, 5'h01 << ch);
      mcu.rd(1'b0, 5'h01 << ch, 1'b0);
      cyc(2);
      chk("ots", overtemp_shutdown, 5'h00);
      chk("out_en", out_en, exp_en(5'h1f, 5'h01 << ch));
      mcu.wr_on(5'h1f);
      cyc(3);
      chk("out_en", out_en, 5'h1f);
      // fail mode overtemp needs a mode transition
      @(posedge clk) fail_mode <= 1'b1;
      ch = $urandom_range(4, 0);
      @(posedge clk) ot_raw[ch] <= 1'b1;
      cyc(OT_N + 10);
      @(posedge clk) ot_raw[ch] <= 1'b0;
      cyc(4);
      mcu.wr_on(5'h1f);
      cyc(4);
      chk("out_en", out_en, exp_en(5'h1f, 5'h01 << ch));
      @(posedge clk) mode_trans <= 1'b1;
      @(posedge clk) mode_trans <= 1'b0;
      cyc(4);
      chk("out_en", out_en, 5'h1f);
      mcu.rd(1'b0, 5'h01 << ch, 1'b0);
      // fail mode undervoltage restarts by itself
      @(posedge clk) uv_raw <= 1'b1;
      cyc(UV_N + 10);
      chk("out_en", out_en, 5'h00);
      @(posedge clk) uv_raw <= 1'b0;
      cyc(2 * AR_N + 10);
      chk("out_en", out_en, 5'h1f);
      chk("bat_low", 5'(bat_low), 5'h01);
      mcu.rd(1'b0, 5'h00, 1'b1);
      cyc(2);
      chk("bat_low", 5'(bat_low), 5'h00);
      @(posedge clk) fail_mode <= 1'b0;
      // normal mode undervoltage needs write, battery low needs read
      @(posedge clk) uv_raw <= 1'b1;
      cyc(UV_N + 10);
      chk("out_en", out_en, 5'h00);
      chk("bat_low", 5'(bat_low), 5'h01);
      chk("summary", 5'(summary), 5'h01);
      mcu.rd(1'b0, 5'h00, 1'b1);
      cyc(2);
      chk("bat_low", 5'(bat_low), 5'h01);
      @(posedge clk) uv_raw <= 1'b0;
      cyc(3 * AR_N);
      chk("out_en", out_en, 5'h00);
      mcu.rd(1'b0, 5'h00, 1'b1);
      cyc(3);
      chk("bat_low", 5'(bat_low), 5'h00);
      chk("summary", 5'(summary), 5'h00);
      mcu.wr_on(5'h1f);
      cyc(3);
      chk("out_en", out_en, 5'h1f);
      // overvoltage flags only
      @(posedge clk) ov_raw <= 1'b1;
      cyc(UV_N + 10);
      chk("bat_high", 5'(bat_high), 5'h01);
      chk("out_en", out_en, 5'h1f);
      chk("summary", 5'(summary), 5'h01);
      mcu.rd(1'b0, 5'h00, 1'b1);
      cyc(2);
      chk("bat_high", 5'(bat_high), 5'h01);
      @(posedge clk) ov_raw <= 1'b0;
      cyc(4);
      mcu.rd(1'b0, 5'h00, 1'b1);
      cyc(3);
      chk("bat_high", 5'(bat_high), 5'h00);
      // pump failure with a command held meanwhile
      @(posedge clk) cp_bad <= 1'b1;
      cyc(CP_N + 10);
      chk("out_en", out_en, 5'h00);
      chk("pump_fail", 5'(pump_fail), 5'h01);
      chk("summary", 5'(summary), 5'h01);
      cnt0 = inrush_cnt;
      mcu.wr_on(5'h0a);
      cyc(4);
      chk("out_en", out_en, 5'h00);
      @(posedge clk) cp_bad <= 1'b0;
      cyc(6);
      chk("out_en", out_en, 5'h0a);
      chk("inrush", 5'(inrush_cnt - cnt0), 5'h02);
      chk("pump_fail", 5'(pump_fail), 5'h01);
      mcu.rd(1'b1, 5'h00, 1'b0);
      cyc(2);
      chk("pump_fail", 5'(pump_fail), 5'h00);
      // random on patterns, a few idle cycles apart, with short overvoltage glitches
      repeat (8)
      begin
         d = 5'($urandom);
         @(posedge clk) ov_raw <= 1'($urandom);
         mcu.wr_on(d);
         cyc(3);
         chk("out_en", out_en, exp_en(d, 5'h00));
         chk("bat_high", 5'(bat_high), 5'h00);
      end
      end_sim();
   end
endmodule : stfm_fault_mgr_tb_top

`default_nettype wire
